/* dtc_pkg.sv */
// Package for the dual 8-bit cascadable timer.
// Assumes a single 20 MHz clock and CPU-side control held outside as plain ports.
package dtc_pkg;

  // Clock and prescaler
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned DIV_A = 8;
  localparam int unsigned DIV_B = 64;
  localparam int unsigned PRE_W = 6;

  // Counter limits
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] COR_RESET = 8'hFF;

  // Clock-select codes
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_FULL = 3'h1;
  localparam logic [2:0] CKS_DIV_A = 3'h2;
  localparam logic [2:0] CKS_DIV_B = 3'h3;
  localparam logic [2:0] CKS_CASCADE = 3'h4;

  // Clear-select codes {clear_select_hi, clear_select_lo}
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH = 2'h1;
  localparam logic [1:0] CLR_EXT = 2'h3;

  // Output-select codes for the match output pin
  localparam logic [1:0] OSEL_KEEP = 2'h0;
  localparam logic [1:0] OSEL_LOW = 2'h1;
  localparam logic [1:0] OSEL_HIGH = 2'h2;
  localparam logic [1:0] OSEL_TOGGLE = 2'h3;

  // Per-channel configuration bundle
  typedef struct packed {
    logic [2:0] clock_select;
    logic clear_select_hi;
    logic clear_select_lo;
    logic [1:0] output_select;
  } dtc_cfg_s;

endpackage : dtc_pkg

/* dtc_timer.sv */
// Dual 8-bit up-counter with compare match, wrap flag and cascade modes.
// Assumes CPU write strobes are one-cycle pulses on clock_in marking the
// second state of the write; the external clear pin is asynchronous.

// Function
// - A channel's wrap flag is set when its counter rolls from FF to 00.
// - The channels are cascaded when either clock select holds the cascade code.
// - Cascade code on channel 0 makes one 16-bit counter, channel 0 upper, channel 1 lower.
// - In 16-bit mode channel 0's match flag sets only on a full 16-bit match.
// - In 16-bit mode channel 1's match flag sets on a lower-byte match.
// - In 16-bit mode, match clear on channel 0 zeroes both bytes, even with external clear chosen.
// - In 16-bit mode channel 1's clear select is ignored and the low byte never clears alone.
// - In 16-bit mode pin 0 follows channel 0's output select on the 16-bit match.
// - In 16-bit mode pin 1 follows channel 1's output select on the lower-byte match.
// - Cascade code on channel 1 alone makes channel 1 count channel 0's compare match events.
// - In match-count mode each channel handles flags, pins and clearing on its own settings.
// - A counter write coinciding with a count tick stores the data and drops the tick.
// - A compare write coinciding with a match completes and suppresses that match's flag and pin action, but not its counter clear.
module dtc_timer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Per-channel configuration
  input wire dtc_pkg::dtc_cfg_s channel_control_0_in,
  input wire dtc_pkg::dtc_cfg_s channel_control_1_in,
  // CPU writes, one strobe bit per channel, 8-bit data shared by both
  input wire logic [1:0] count_wr_in,
  input wire logic [7:0] count_wdata_in,
  input wire logic [1:0] compare_wr_in,
  input wire logic [7:0] compare_wdata_in,
  // Flag clears and interrupt enables, one bit per channel
  input wire logic [1:0] match_clear_in,
  input wire logic [1:0] wrap_clear_in,
  input wire logic [1:0] match_irq_en_in,
  input wire logic [1:0] wrap_irq_en_in,
  // External clear pin
  input wire logic external_clear_input_0_in,
  // Counter state
  output logic [7:0] count_value_0_out,
  output logic [7:0] count_value_1_out,
  output logic cascade_out,
  // Flags and interrupts
  output logic [1:0] match_flag_out,
  output logic [1:0] wrap_flag_out,
  output logic [1:0] match_irq_out,
  output logic [1:0] wrap_irq_out,
  // Compare match pins
  output logic match_output_pin_0_out,
  output logic match_output_pin_1_out
);

  logic [dtc_pkg::PRE_W-1:0] pre_ff, nxt_pre;
  logic [7:0] cnt_ff [2];
  logic [7:0] nxt_cnt [2];
  logic [7:0] cor_ff [2];
  logic [7:0] nxt_cor [2];
  logic [1:0] mflag_ff, nxt_mflag, wflag_ff, nxt_wflag;
  logic [1:0] pin_ff, nxt_pin, mprev_ff, nxt_mprev;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic tick_a, tick_b, mode16, mcount, ext_edge, clear16;
  logic [1:0] tick, mlevel, mevt, clr;
  dtc_pkg::dtc_cfg_s cfg [2];

  // Prescaler enables; first ticks when the prescaler reaches 7 (A) and 63 (B)
  always_comb begin
    nxt_pre = pre_ff + 1'b1;
    tick_a = (pre_ff[2:0] == 3'h7);
    tick_b = (pre_ff == 6'h3F);
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // Two-stage synchroniser, third stage only for the edge detect
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= external_clear_input_0_in;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  function automatic logic sel_tick(input logic [2:0] cks, input logic ta, input logic tb);
    logic t;
    t = 1'b0;
    case (cks)
      dtc_pkg::CKS_FULL: t = 1'b1;
      dtc_pkg::CKS_DIV_A: t = ta;
      dtc_pkg::CKS_DIV_B: t = tb;
      default: t = 1'b0;
    endcase
    return t;
  endfunction : sel_tick

  // Mode decode, compare, ticks, clears and next state
  always_comb begin
    cfg[0] = channel_control_0_in;
    cfg[1] = channel_control_1_in;
    mode16 = (cfg[0].clock_select == dtc_pkg::CKS_CASCADE);
    mcount = !mode16 && (cfg[1].clock_select == dtc_pkg::CKS_CASCADE);
    cascade_out = mode16 || mcount;
    ext_edge = ext_s2_ff && !ext_s3_ff;
    // 16-bit match for channel 0 in 16-bit mode, byte match otherwise
    mlevel[0] = mode16 ? ({cnt_ff[0], cnt_ff[1]} == {cor_ff[0], cor_ff[1]})
                       : (cnt_ff[0] == cor_ff[0]);
    mlevel[1] = (cnt_ff[1] == cor_ff[1]);
    // A compare write in the same cycle wins over the match
    mevt = mlevel & ~mprev_ff & ~compare_wr_in;
    nxt_mprev = mlevel;
    // Channel 1 counts channel 0 matches in match-count mode
    tick[1] = mcount ? mevt[0] : sel_tick(cfg[1].clock_select, tick_a, tick_b);
    // A low-byte write drops its tick, so it carries nothing upward either
    tick[0] = mode16 ? (tick[1] && !count_wr_in[1] && cnt_ff[1] == dtc_pkg::CNT_MAX)
                     : sel_tick(cfg[0].clock_select, tick_a, tick_b);
    // In 16-bit mode either clear choice on channel 0 clears on the 16-bit match
    clear16 = (tick[1] && mlevel[0] && ({cfg[0].clear_select_hi, cfg[0].clear_select_lo}
               == dtc_pkg::CLR_MATCH || {cfg[0].clear_select_hi, cfg[0].clear_select_lo}
               == dtc_pkg::CLR_EXT)) || ({cfg[0].clear_select_hi, cfg[0].clear_select_lo}
               == dtc_pkg::CLR_EXT && ext_edge);
    for (int i = 0; i < 2; i++) begin
      clr[i] = (tick[i] && mlevel[i]
                && {cfg[i].clear_select_hi, cfg[i].clear_select_lo} == dtc_pkg::CLR_MATCH)
               || (i == 0 && ext_edge
                && {cfg[i].clear_select_hi, cfg[i].clear_select_lo} == dtc_pkg::CLR_EXT);
    end
    if (mode16) begin
      clr = {clear16, clear16};
    end
    for (int i = 0; i < 2; i++) begin
      nxt_cor[i] = compare_wr_in[i] ? compare_wdata_in : cor_ff[i];
      nxt_cnt[i] = cnt_ff[i];
      nxt_wflag[i] = wflag_ff[i] && !wrap_clear_in[i];
      nxt_mflag[i] = (mflag_ff[i] && !match_clear_in[i]) || mevt[i];
      nxt_pin[i] = pin_ff[i];
      if (count_wr_in[i]) begin
        nxt_cnt[i] = count_wdata_in;
      end else if (clr[i]) begin
        nxt_cnt[i] = dtc_pkg::CNT_ZERO;
      end else if (tick[i]) begin
        nxt_cnt[i] = cnt_ff[i] + 8'h01;
        if (cnt_ff[i] == dtc_pkg::CNT_MAX) begin
          nxt_wflag[i] = 1'b1;
        end
      end
      // Pin action on the channel's own match event
      if (mevt[i]) begin
        case (cfg[i].output_select)
          dtc_pkg::OSEL_LOW: nxt_pin[i] = 1'b0;
          dtc_pkg::OSEL_HIGH: nxt_pin[i] = 1'b1;
          dtc_pkg::OSEL_TOGGLE: nxt_pin[i] = !pin_ff[i];
          default: nxt_pin[i] = pin_ff[i];
        endcase
      end
    end
  end

  // Channel state registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 2; i++) begin
        cnt_ff[i] <= dtc_pkg::CNT_ZERO;
        cor_ff[i] <= dtc_pkg::COR_RESET;
      end
      mflag_ff <= 2'h0;
      wflag_ff <= 2'h0;
      pin_ff <= 2'h0;
      mprev_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
        cor_ff[i] <= nxt_cor[i];
      end
      mflag_ff <= nxt_mflag;
      wflag_ff <= nxt_wflag;
      pin_ff <= nxt_pin;
      mprev_ff <= nxt_mprev;
    end
  end

  // Outputs straight from flops; requests gated by enables
  assign count_value_0_out = cnt_ff[0];
  assign count_value_1_out = cnt_ff[1];
  assign match_flag_out = mflag_ff;
  assign wrap_flag_out = wflag_ff;
  assign match_irq_out = mflag_ff & match_irq_en_in;
  assign wrap_irq_out = wflag_ff & wrap_irq_en_in;
  assign match_output_pin_0_out = pin_ff[0];
  assign match_output_pin_1_out = pin_ff[1];

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_wrap_sets_flag: assert property ((tick[0] && !count_wr_in[0] && !clr[0]
    && cnt_ff[0] == 8'hFF) |=> wflag_ff[0] && cnt_ff[0] == 8'h00)
    else $error("wrap did not set flag");
  a_cascade_mode: assert property (cascade_out == (channel_control_0_in.clock_select == 3'h4
    || channel_control_1_in.clock_select == 3'h4))
    else $error("cascade decode wrong");
  a_carry_upper_byte: assert property ((mode16 && tick[1] && !clr[1] && !count_wr_in[0]
    && !count_wr_in[1]
    && cnt_ff[1] == 8'hFF) |=> cnt_ff[0] == $past(cnt_ff[0]) + 8'h01)
    else $error("16-bit carry missing");
  a_match16_only: assert property ((mode16 && $past(mode16) && !$past(mprev_ff[0])
    && $rose(mflag_ff[0]))
    |-> $past({cnt_ff[0], cnt_ff[1]} == {cor_ff[0], cor_ff[1]}))
    else $error("channel 0 flag without 16-bit match");
  a_clear_both: assert property ((mode16 && clear16 && count_wr_in == 2'h0)
    |=> cnt_ff[0] == 8'h00 && cnt_ff[1] == 8'h00)
    else $error("16-bit clear incomplete");
  a_low_no_own_clr: assert property ((mode16 && !clear16 && !count_wr_in[1] && tick[1]
    && cnt_ff[1] != 8'hFF) |=> cnt_ff[1] == $past(cnt_ff[1]) + 8'h01)
    else $error("low byte cleared alone");
  a_match_count: assert property ((mcount && mevt[0] && !count_wr_in[1] && !clr[1])
    |=> cnt_ff[1] == $past(cnt_ff[1]) + 8'h01)
    else $error("match count missed");
  a_write_wins: assert property (count_wr_in[1] |=> cnt_ff[1] == $past(count_wdata_in))
    else $error("count write lost");
  a_cmp_suppress: assert property ((compare_wr_in[1] && !mflag_ff[1])
    |=> !mflag_ff[1])
    else $error("match not suppressed");
  a_irq_follows: assert property (mevt[0]
    |=> mflag_ff[0] && (match_irq_out[0] == match_irq_en_in[0]))
    else $error("interrupt not raised");

  c_mode16_match: cover property (mode16 && mevt[0]);
  c_mcount_tick: cover property (mcount && mevt[0] ##1 cnt_ff[1] != 8'h00);
  c_write_conflict: cover property (count_wr_in[0] && tick[0]);

endmodule : dtc_timer

/* dtc_timer_tb.sv */
// Self-checking bench for the dual 8-bit timer: a cycle model checked at every clock.
// Assumes the timer and its package; ext clear pulsed at random, every clock rate driven.
module dtc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
    $display("FAIL %s expected %0h seen %0h", n, e, s); end end
  logic clock_in, resetn_in, ext, casc, p0, p1, s16, cl, ta, tb, xe;
  logic [2:0] es;
  dtc_pkg::dtc_cfg_s cfg0, cfg1;
  logic [1:0] cwr, kwr, mclr, wclr, mien, wien, rep, mfo, wfo, mio, wio;
  logic [1:0] eq, eqp, ev, tk, clr, go, mfl, wfl, pin;
  logic [7:0] cwd, kwd, c0o, c1o;
  logic [7:0] mc [2];
  logic [7:0] mk [2];
  logic [31:0] rnd;
  int err_count, tests_run, cyc, pc;

  dtc_timer uut (.clock_in(clock_in), .resetn_in(resetn_in), .channel_control_0_in(cfg0),
    .channel_control_1_in(cfg1), .count_wr_in(cwr), .count_wdata_in(cwd),
    .compare_wr_in(kwr), .compare_wdata_in(kwd), .match_clear_in(mclr),
    .wrap_clear_in(wclr), .match_irq_en_in(mien), .wrap_irq_en_in(wien),
    .external_clear_input_0_in(ext), .count_value_0_out(c0o), .count_value_1_out(c1o),
    .cascade_out(casc), .match_flag_out(mfo), .wrap_flag_out(wfo), .match_irq_out(mio),
    .wrap_irq_out(wio), .match_output_pin_0_out(p0), .match_output_pin_1_out(p1));

  // Free-running 20 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Tick choice from the clock-select code; unlisted codes stop the channel
  function automatic logic pick(input logic [2:0] k, input logic a, input logic b);
    return k == dtc_pkg::CKS_FULL || (k == dtc_pkg::CKS_DIV_A && a)
      || (k == dtc_pkg::CKS_DIV_B && b);
  endfunction : pick

  // Reference model; match event is the rising edge of equality
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mc = '{8'h00, 8'h00};
      mk = '{8'hFF, 8'hFF};
      {eqp, mfl, wfl, pin} = '0;
      es = '0;
      pc = 0;
    end else begin
      s16 = cfg0.clock_select == dtc_pkg::CKS_CASCADE;
      // Pin edge seen after two sync stages, as the design sees it
      xe = es[1] && !es[2] && cfg0.clear_select_hi && cfg0.clear_select_lo;
      es = {es[1:0], ext};
      ta = pc % dtc_pkg::DIV_A == dtc_pkg::DIV_A - 1;
      tb = pc % dtc_pkg::DIV_B == dtc_pkg::DIV_B - 1;
      pc++;
      eq[1] = mc[1] == mk[1];
      eq[0] = s16 ? {mc[0], mc[1]} == {mk[0], mk[1]} : mc[0] == mk[0];
      ev = eq & ~eqp & ~kwr;
      eqp = eq;
      tk[0] = pick(cfg0.clock_select, ta, tb);
      tk[1] = pick(cfg1.clock_select, ta, tb) ||
        (!s16 && cfg1.clock_select == dtc_pkg::CKS_CASCADE && ev[0]);
      cl = (tk[1] && eq[0] && cfg0.clear_select_lo) || xe;
      clr[0] = eq[0] && cfg0.clear_select_lo && !cfg0.clear_select_hi;
      clr[1] = eq[1] && cfg1.clear_select_lo && !cfg1.clear_select_hi;
      if (s16) begin
        tk[0] = tk[1] && !cwr[1] && mc[1] == 8'hFF && !cl; // Carry into the upper byte
      end
      tk = tk & ~cwr;
      go = s16 ? {cl, cl} : (tk & clr) | {1'b0, xe};
      for (int i = 0; i < 2; i++) begin
        if (tk[i] && !go[i] && mc[i] == 8'hFF) wfl[i] = 1'b1;
        else if (wclr[i]) wfl[i] = 1'b0;
        if (cwr[i]) mc[i] = cwd;
        else if (go[i]) mc[i] = 8'h00;
        else if (tk[i]) mc[i] = mc[i] + 8'h01;
        if (kwr[i]) mk[i] = kwd;
        if (ev[i]) begin
          mfl[i] = 1'b1;
          case (i ? cfg1.output_select : cfg0.output_select)
            dtc_pkg::OSEL_LOW: pin[i] = 1'b0;
            dtc_pkg::OSEL_HIGH: pin[i] = 1'b1;
            dtc_pkg::OSEL_TOGGLE: pin[i] = ~pin[i];
            default: ;
          endcase
        end else if (mclr[i]) begin
          mfl[i] = 1'b0;
        end
      end
    end
  end

  // Compare mid-cycle, when both sides have settled
  always @(negedge clock_in) begin
    `CHK("count_value_0", mc[0], c0o)
    `CHK("count_value_1", mc[1], c1o)
    `CHK("match_flag", mfl, mfo)
    `CHK("wrap_flag", wfl, wfo)
    `CHK("match_irq", mfl & mien, mio)
    `CHK("wrap_irq", wfl & wien, wio)
    `CHK("match_pins", pin, {p1, p0})
    `CHK("cascade", cfg0.clock_select == 3'h4 || cfg1.clock_select == 3'h4, casc)
  end

  // Hang guard, well above the roughly 11000 cycles of stimulus
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic do_reset();
    resetn_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #5;
    resetn_in = 1'b1;
  endtask : do_reset

  // Config held per phase; strobes random, data OR-masked to steer counts high
  task automatic phase(input logic [2:0] k0, input logic [2:0] k1, input logic [1:0] cm,
                       input logic [1:0] km, input logic [7:0] dm, input int n);
    repeat (n) begin
      @(posedge clock_in);
      #5;
      rnd = lfsr(rnd);
      cfg0 = '{k0, rep[1], rep[0], rep};
      cfg1 = '{k1, ~rep[0], rep[1], ~rep};
      cwr = cm & rnd[1:0] & {2{&rnd[4:2]}};
      kwr = km & rnd[6:5] & {2{&rnd[9:7]}};
      cwd = rnd[17:10] | dm;
      kwd = rnd[25:18] | dm;
      mclr = rnd[27:26] & {2{rnd[28]}};
      wclr = rnd[30:29] & {2{rnd[31]}};
      mien = rnd[3:2];
      wien = rnd[8:7];
      ext = &rnd[15:12];
    end
  endtask : phase

  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Every clear and output code, each mode, and a second reset mid-run
  initial begin
    rnd = 32'h1C9B8A21;
    {cwr, kwr, mclr, wclr, mien, wien, cwd, kwd, ext, rep} = '0;
    cfg0 = '0;
    cfg1 = '0;
    do_reset();
    for (int r = 0; r < 4; r++) begin
      rep = r[1:0];
      if (r == 2) do_reset();
      phase(dtc_pkg::CKS_STOP, 3'h7, 2'h3, 2'h3, 8'hF0, 20);
      phase(dtc_pkg::CKS_FULL, dtc_pkg::CKS_FULL, 2'h3, 2'h3, 8'h00, 600);
      phase(dtc_pkg::CKS_FULL, dtc_pkg::CKS_CASCADE, 2'h3, 2'h3, 8'h00, 600);
      phase(dtc_pkg::CKS_DIV_A, dtc_pkg::CKS_DIV_B, 2'h1, 2'h3, 8'hF8, 600);
      phase(dtc_pkg::CKS_STOP, dtc_pkg::CKS_STOP, 2'h3, 2'h3, 8'hF0, 20);
      phase(dtc_pkg::CKS_CASCADE, dtc_pkg::CKS_FULL, 2'h3, 2'h0, 8'hF0, 800);
      phase(dtc_pkg::CKS_CASCADE, dtc_pkg::CKS_CASCADE, 2'h3, 2'h0, 8'h00, 50);
    end
    results();
  end
endmodule : dtc_timer_tb
